/* dv/lspt_mem_model.sv */
// Purpose: memory side of the store slot, fetch unit and bus waits
// Assumes: changes only just after rising edges
// Notes: random waits, seeded once by the bench
`timescale 1ns/1ns
module lspt_mem_model (
	input  wire logic clk,
	output logic      st_ready,
	output logic      mem_stall,
	output logic      fetch_busy
);
	initial begin
		st_ready   = 1'b0;
		mem_stall  = 1'b0;
		fetch_busy = 1'b0;
	end
	// slow drain of the single entry
	always @(posedge clk) begin
		st_ready   <= ($urandom % 3) == 0;
		mem_stall  <= ($urandom % 8) == 0;
		fetch_busy <= ($urandom % 2) == 0;
	end
endmodule

/* dv/tb.sv */
// Purpose: issue-cost and register bench of the lsu timing core
// Assumes: clk_en held high
// Notes: costs are read back from the cost register
`timescale 1ns/1ns
`include "lspt_map.svh"
module tb;
	logic                  clk, reset, psel, penable, pwrite, pready, pslverr;
	logic                  iv, ir, stv, st_ready, mem_stall, fetch_busy, fault, pb;
	logic [11:0]           paddr;
	logic [31:0]           pwdata, prdata, dres;
	logic [3:0]            flags;
	lspt_pkg::lspt_issue_s iss;
	lspt_pkg::lspt_store_s st_req;
	int                    err_count, n_checks, cyc;
	logic [31:0]           q[$];
	logic                  irq, fb, qe[$];
	logic [63:0]           sq[$];
	lspt_pkg::lspt_issue_s tm;
	lspt_core lspt_core_i (.clk(clk), .reset(reset), .clk_en(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .issue_valid(iv),
		.issue(iss), .issue_ready(ir), .fetch_busy(fetch_busy), .mem_stall(mem_stall),
		.irq_req(irq), .st_valid(stv), .st_req(st_req), .st_ready(st_ready),
		.dsp_result(dres), .lane_result_flags(flags), .unaligned_fault(fault),
		.pipe_busy(pb));
	lspt_mem_model lspt_mem_model_i (.clk(clk), .st_ready(st_ready),
		.mem_stall(mem_stall), .fetch_busy(fetch_busy));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task close_out;
		if (err_count == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// ----------------------------------------
	// drivers
	// ----------------------------------------
	// word transfers only
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk) penable <= 1'b1;
		@(negedge clk);
		while (pready !== 1'b1) @(negedge clk);
		@(posedge clk);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		q.push_back(e);
		qe.push_back(a > `LSPT_OFF_COST || a[1:0] != 2'h0);
		apb(1'b0, a, 32'h0);
	endtask
	task fire(input lspt_pkg::lspt_op_e op, input lspt_pkg::lspt_size_e sz,
		input logic [31:0] a, input logic [4:0] n, input logic [3:0] dst);
		lspt_pkg::lspt_issue_s t;
		t = tm; t.op = op; t.size = sz; t.addr = a; t.count = n;
		t.dest = dst;
		if (op == lspt_pkg::OP_STORE) sq.push_back({t.addr, t.data});
		@(posedge clk);
		iss <= t; iv <= 1'b1;
		@(negedge clk);
		while (ir !== 1'b1) @(negedge clk);
		fb = fetch_busy;
		@(posedge clk) iv <= 1'b0;
		@(negedge clk);
		while (pb !== 1'b0) @(negedge clk);
	endtask
	// pre of 4'hf means no preceding data operation
	task go(input lspt_pkg::lspt_op_e op, input lspt_pkg::lspt_size_e sz,
		input logic [31:0] a, input logic [4:0] n, input logic [3:0] pre, input logic [31:0] e);
		if (pre != 4'hf) fire(lspt_pkg::OP_DP, lspt_pkg::SZ_WORD, 32'h0, 5'h0, pre);
		fire(op, sz, a, n, 4'hf);
		rd(`LSPT_OFF_COST, e);
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(negedge clk) begin
		logic [63:0] s;
		if (psel && penable && pready && !pwrite) begin
			chk("prdata", q.pop_front(), prdata);
			chk("pslverr", {31'h0, qe.pop_front()}, {31'h0, pslverr});
		end
		if (stv === 1'b1 && st_ready === 1'b1) begin
			s = sq.pop_front();
			chk("st_req.addr", s[63:32], st_req.addr);
			chk("st_req.data", s[31:0], st_req.data);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		logic [31:0] a;
		int          k;
		logic [3:0]  ef;
		reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
		pwdata = 32'h0; iv = 1'b0; iss = '0; err_count = 0; n_checks = 0; cyc = 0;
		irq = 1'b0;
		tm = '0;
		tm.buffered = 1'b1;
		void'($urandom(32'h3f71d74f));
		tm.data = $urandom;
		tm.opb = $urandom;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		a = $urandom & 32'hfffffffc;
		rd(`LSPT_OFF_CTRL, 32'h1);
		rd(`LSPT_OFF_CFG, 32'h0);
		rd(12'h040, 32'h0);
		go(lspt_pkg::OP_DSP, lspt_pkg::SZ_WORD, a, 5'h0, 4'he, 32'h1);
		ef = {{2{tm.data[31:16] >= tm.opb[31:16]}}, {2{tm.data[15:0] >= tm.opb[15:0]}}};
		chk("dsp_result", {tm.data[31:16] - tm.opb[31:16],
			tm.data[15:0] - tm.opb[15:0]}, dres);
		chk("lane_result_flags", {28'h0, ef}, {28'h0, flags});
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'he, 32'h2);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf, 32'h1);
		go(lspt_pkg::OP_STORE, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf, 32'h1);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf, 32'h2);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'h0, 32'h3);
		go(lspt_pkg::OP_LOAD_PC, lspt_pkg::SZ_WORD, a, 5'h0, 4'he, 32'h5);
		go(lspt_pkg::OP_TBRANCH, lspt_pkg::SZ_BYTE, a, 5'h0, 4'he, 32'h6);
		go(lspt_pkg::OP_LOAD_PAIR, lspt_pkg::SZ_WORD, a, 5'h0, 4'he, 32'h3);
		go(lspt_pkg::OP_LOAD_MULTI, lspt_pkg::SZ_WORD, a, 5'h3, 4'he, 32'h5);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a | 32'h1, 5'h0, 4'he, 32'h4);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_HALF, a | 32'h1, 5'h0, 4'he, 32'h3);
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a | 32'h2, 5'h0, 4'he, 32'h3);
		tm.excl = 1'b1;
		go(lspt_pkg::OP_STORE, lspt_pkg::SZ_WORD, a, 5'h0, 4'he, 32'h2);
		tm.excl = 1'b0;
		go(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf, 32'h1);
		tm.pc_rel = 1'b1;
		fire(lspt_pkg::OP_DP, lspt_pkg::SZ_WORD, 32'h0, 5'h0, 4'he);
		fire(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf);
		tm.pc_rel = 1'b0;
		rd(`LSPT_OFF_COST, 32'h2 + {31'h0, fb});
		tm.dctl.mode = lspt_pkg::DM_SAT;
		tm.dctl.lanes8 = 1'b1;
		tm.dctl.sgn = 1'b1;
		tm.data = 32'h8080_8080;
		tm.opb = ($urandom & 32'h7f7f_7f7f) | 32'h0101_0101;
		go(lspt_pkg::OP_DSP, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf, 32'h1);
		chk("dsp_result", 32'h8080_8080, dres);
		rd(`LSPT_OFF_FLAGS, {27'h0, 1'b1, ef});
		apb(1'b1, `LSPT_OFF_FLAGS, 32'h10);
		rd(`LSPT_OFF_FLAGS, {28'h0, ef});
		tm.dctl = '0;
		apb(1'b1, `LSPT_OFF_CTRL, 32'h0);
		fire(lspt_pkg::OP_STORE, lspt_pkg::SZ_WORD, a, 5'h0, 4'hf);
		k = 0;
		while (stv === 1'b1 && k < 50) begin
			chk("issue_ready", 32'h0, {31'h0, ir});
			@(negedge clk);
			k++;
		end
		apb(1'b1, `LSPT_OFF_CTRL, 32'h1);
		apb(1'b1, `LSPT_OFF_CFG, 32'h3);
		rd(`LSPT_OFF_CFG, 32'h3);
		fire(lspt_pkg::OP_LOAD, lspt_pkg::SZ_WORD, a | 32'h1, 5'h0, 4'he);
		chk("unaligned_fault", 32'h1, {31'h0, fault});
		rd(`LSPT_OFF_COST, 32'h1);
		irq <= 1'b1;
		fire(lspt_pkg::OP_LOAD_MULTI, lspt_pkg::SZ_WORD, a, 5'h08, 4'he);
		@(posedge clk) irq <= 1'b0;
		rd(`LSPT_OFF_STATUS, 32'h0000_0808);
		fire(lspt_pkg::OP_LOAD_MULTI, lspt_pkg::SZ_WORD, a, 5'h08, 4'he);
		rd(`LSPT_OFF_COST, 32'h0000_000b);
		repeat (4) @(posedge clk);
		chk("stores left", 32'h0, sq.size());
		close_out();
	end
endmodule

/* verilog/lspt_core.sv */
// Purpose: issue timing of loads, stores, blocking branches and dsp subtracts
// Assumes: one clock, synchronous inputs, memory drains the store slot by st_ready
// Notes: apb answers one cycle after setup while clk_en is high
`timescale 1ns/1ns
`include "lspt_map.svh"
module lspt_core (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  clk_en,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  issue_valid,
	input  wire lspt_pkg::lspt_issue_s issue,
	output logic                       issue_ready,
	input  wire logic                  fetch_busy,
	input  wire logic                  mem_stall,
	input  wire logic                  irq_req,
	output logic                       st_valid,
	output lspt_pkg::lspt_store_s      st_req,
	input  wire logic                  st_ready,
	output logic [31:0]                dsp_result,
	output logic [3:0]                 lane_result_flags,
	output logic                       unaligned_fault,
	output logic                       pipe_busy
);
	logic                  fire;
	logic                  dsp_fire;
	logic                  is_mem;
	logic                  is_single;
	logic                  is_multi;
	logic                  uses_prev;
	logic                  dep_dp;
	logic                  pipe_ok;
	logic                  trap_hit;
	logic                  st_done;
	logic                  apb_wr;
	logic                  apb_hit;
	logic [7:0]            unal_pen;
	logic [7:0]            cost;
	logic [4:0]            elems;
	logic [31:0]           rd_data;
	logic [31:0]           dres;
	logic [3:0]            dge;
	logic                  dsat;
	lspt_pkg::lspt_state_e state_reg;
	logic [7:0]            cnt_reg;
	logic [7:0]            cost_reg;
	logic                  multi_reg;
	logic                  resume_reg;
	logic [4:0]            resume_elems_reg;
	logic                  prev_dp_reg;
	logic                  prev_ld_reg;
	logic [3:0]            prev_dest_reg;
	logic                  slot_full_reg;
	logic                  slot_hard_reg;
	lspt_pkg::lspt_store_s st_req_reg;
	logic [31:0]           dsp_res_reg;
	logic [3:0]            ge_reg;
	logic                  sat_reg;
	logic                  wb_en_reg;
	logic                  trap_reg;
	logic                  align_reg;
	logic                  fault_reg;
	logic                  ld_reg;
	logic [31:0]           prdata_reg;

	// ----------------------------------------
	// issue decode
	// ----------------------------------------
	assign is_mem    = issue.op >= lspt_pkg::OP_LOAD;
	assign is_multi  = issue.op >= lspt_pkg::OP_LOAD_MULTI;
	assign is_single = (issue.op == lspt_pkg::OP_LOAD) || (issue.op == lspt_pkg::OP_STORE);
	assign uses_prev = (issue.base == prev_dest_reg) ||
		(issue.reg_off && issue.index == prev_dest_reg);
	assign dep_dp    = is_mem && prev_dp_reg && uses_prev;
	assign pipe_ok   = is_single && prev_ld_reg && !uses_prev;
	assign trap_hit  = is_single && trap_reg && (unal_pen != 8'h00);
	assign st_done   = slot_full_reg && st_ready;
	assign dsp_fire  = fire && issue.op == lspt_pkg::OP_DSP;

	assign issue_ready = clk_en && (state_reg == lspt_pkg::ST_IDLE) && !slot_hard_reg &&
		!(is_mem && slot_full_reg && !st_ready);
	assign fire = issue_valid && issue_ready;

	always_comb begin
		unal_pen = 8'h00;
		if (issue.size == lspt_pkg::SZ_HALF && issue.addr[0]) begin
			unal_pen = `LSPT_CYC_ONE;
		end else if (issue.size == lspt_pkg::SZ_WORD && issue.addr[0]) begin
			unal_pen = `LSPT_CYC_ONE + `LSPT_CYC_ONE;
		end else if (issue.size == lspt_pkg::SZ_WORD && issue.addr[1]) begin
			unal_pen = `LSPT_CYC_ONE;
		end
	end

	// ----------------------------------------
	// cycle cost of the issued instruction
	// ----------------------------------------
	always_comb begin
		elems = resume_reg ? resume_elems_reg : issue.count;
		cost = `LSPT_CYC_ONE;
		unique case (issue.op)
			lspt_pkg::OP_LOAD: cost = `LSPT_CYC_LOAD;
			lspt_pkg::OP_STORE: cost = (issue.reg_off || issue.excl) ? `LSPT_CYC_LOAD
				: `LSPT_CYC_ONE;
			lspt_pkg::OP_LOAD_PC: cost = `LSPT_CYC_LOAD + `LSPT_CYC_REFILL;
			lspt_pkg::OP_TBRANCH: cost = `LSPT_CYC_LOAD + `LSPT_CYC_ADD + `LSPT_CYC_REFILL;
			lspt_pkg::OP_LOAD_PAIR, lspt_pkg::OP_STORE_PAIR: cost = `LSPT_CYC_PAIR;
			lspt_pkg::OP_LOAD_MULTI, lspt_pkg::OP_STORE_MULTI: begin
				cost = `LSPT_CYC_FIRST + {3'h0, elems} - `LSPT_CYC_ONE + `LSPT_CYC_FINAL;
				if (resume_reg) begin
					cost = cost + ((issue.op == lspt_pkg::OP_STORE_MULTI) ?
						`LSPT_CYC_RES_ST : `LSPT_CYC_RES_LD);
				end
			end
			default: cost = `LSPT_CYC_ONE;
		endcase
		if (is_single) begin
			cost = cost + unal_pen;
		end
		if (issue.op == lspt_pkg::OP_LOAD && issue.pc_rel && fetch_busy) begin
			cost = cost + `LSPT_CYC_ONE;
		end
		if (dep_dp) begin
			cost = cost + `LSPT_CYC_ONE;
		end
		if (pipe_ok && cost > `LSPT_CYC_ONE) begin
			cost = cost - `LSPT_CYC_ONE;
		end
		// trapped access never reaches the bus
		if (trap_hit) begin
			cost = `LSPT_CYC_ONE;
		end
	end

	// ----------------------------------------
	// busy counter and multiple resume
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg        <= lspt_pkg::ST_IDLE;
			cnt_reg          <= 8'h00;
			multi_reg        <= 1'b0;
			resume_reg       <= 1'b0;
			resume_elems_reg <= 5'h00;
			cost_reg         <= 8'h00;
		end else if (clk_en) begin
			if (fire) begin
				multi_reg <= is_multi;
				cost_reg  <= cost;
				if (is_multi) begin
					resume_reg <= 1'b0;
				end
				if (cost > `LSPT_CYC_ONE) begin
					state_reg <= lspt_pkg::ST_BUSY;
					cnt_reg   <= cost - `LSPT_CYC_ONE;
				end
			end else if (state_reg == lspt_pkg::ST_BUSY) begin
				if (irq_req && multi_reg && cnt_reg > `LSPT_CYC_ONE) begin
					state_reg        <= lspt_pkg::ST_IDLE;
					cnt_reg          <= 8'h00;
					resume_reg       <= 1'b1;
					resume_elems_reg <= 5'(cnt_reg - `LSPT_CYC_ONE);
				end else if (!mem_stall) begin
					// stalls stretch blocking ops, the count only runs when memory answers
					cnt_reg <= cnt_reg - `LSPT_CYC_ONE;
					if (cnt_reg == `LSPT_CYC_ONE) begin
						state_reg <= lspt_pkg::ST_IDLE;
					end
				end
			end
		end
	end

	// ----------------------------------------
	// pipelining history
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			prev_dp_reg   <= 1'b0;
			prev_ld_reg   <= 1'b0;
			prev_dest_reg <= 4'h0;
		end else if (clk_en && fire) begin
			prev_dp_reg   <= issue.op <= lspt_pkg::OP_DSP;
			// pairs and multiples break the chain
			prev_ld_reg   <= (issue.op == lspt_pkg::OP_LOAD) ||
				(issue.op == lspt_pkg::OP_STORE && issue.excl);
			prev_dest_reg <= issue.dest;
		end
	end

	// ----------------------------------------
	// one-entry store slot
	// ----------------------------------------
	// memory access waits while the slot is full and st_ready is low; buffered store with write buffer off holds issue till drained
	always_ff @(posedge clk) begin
		if (reset) begin
			slot_full_reg <= 1'b0;
			slot_hard_reg <= 1'b0;
			st_req_reg    <= '0;
		end else if (clk_en) begin
			if (fire && issue.op == lspt_pkg::OP_STORE && !trap_hit) begin
				slot_full_reg   <= 1'b1;
				slot_hard_reg   <= issue.buffered && !wb_en_reg;
				st_req_reg.addr <= issue.addr;
				st_req_reg.data <= issue.data;
				st_req_reg.size <= issue.size;
			end else if (st_done) begin
				slot_full_reg <= 1'b0;
				slot_hard_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// dsp unit and flags
	// ----------------------------------------
	lspt_dsp_sub u_dsp (
		.ctl (issue.dctl),
		.opa (issue.data),
		.opb (issue.opb),
		.res (dres),
		.ge  (dge),
		.sat (dsat)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			dsp_res_reg <= 32'h0000_0000;
			ge_reg      <= 4'h0;
			fault_reg   <= 1'b0;
		end else if (clk_en) begin
			fault_reg <= fire && trap_hit;
			if (dsp_fire) begin
				dsp_res_reg <= dres;
				if (issue.dctl.mode == lspt_pkg::DM_FLAG) begin
					ge_reg <= dge;
				end
			end
		end
	end

	// sticky flag, a set in the clearing cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			sat_reg <= 1'b0;
		end else if (clk_en) begin
			if (dsp_fire && dsat) begin
				sat_reg <= 1'b1;
			end else if (apb_wr && paddr == `LSPT_OFF_FLAGS && pwdata[`LSPT_FLAGS_SAT]) begin
				sat_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	assign pready  = psel && penable && ld_reg && clk_en;
	assign apb_wr  = pready && pwrite;
	assign pslverr = pready && !apb_hit;

	always_comb begin
		rd_data = 32'h0000_0000;
		apb_hit = 1'b1;
		case (paddr)
			`LSPT_OFF_CTRL: rd_data[`LSPT_CTRL_WB_EN] = wb_en_reg;
			`LSPT_OFF_CFG: begin
				rd_data[`LSPT_CFG_TRAP]  = trap_reg;
				rd_data[`LSPT_CFG_ALIGN] = align_reg;
			end
			`LSPT_OFF_STATUS: begin
				rd_data[`LSPT_STAT_BUSY]       = state_reg == lspt_pkg::ST_BUSY;
				rd_data[`LSPT_STAT_SLOT]       = slot_full_reg;
				rd_data[`LSPT_STAT_HARD]       = slot_hard_reg;
				rd_data[`LSPT_STAT_RESUME]     = resume_reg;
				rd_data[`LSPT_STAT_ELEMS +: 5] = resume_elems_reg;
			end
			`LSPT_OFF_FLAGS: begin
				rd_data[3:0]              = ge_reg;
				rd_data[`LSPT_FLAGS_SAT]  = sat_reg;
			end
			`LSPT_OFF_COST: rd_data[7:0] = cost_reg;
			default: apb_hit = 1'b0;
		endcase
	end

	// read data is a snapshot taken in the setup cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			ld_reg     <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end else if (clk_en) begin
			if (pready) begin
				ld_reg <= 1'b0;
			end else if (psel && !ld_reg) begin
				ld_reg     <= 1'b1;
				prdata_reg <= rd_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wb_en_reg <= `LSPT_RST_WB_EN;
			trap_reg  <= `LSPT_RST_TRAP;
			align_reg <= `LSPT_RST_ALIGN;
		end else if (apb_wr && paddr == `LSPT_OFF_CTRL) begin
			wb_en_reg <= pwdata[`LSPT_CTRL_WB_EN];
		end else if (apb_wr && paddr == `LSPT_OFF_CFG) begin
			trap_reg  <= pwdata[`LSPT_CFG_TRAP];
			align_reg <= pwdata[`LSPT_CFG_ALIGN];
		end
	end

	assign prdata            = prdata_reg;
	assign st_valid          = slot_full_reg;
	assign st_req            = st_req_reg;
	assign dsp_result        = dsp_res_reg;
	assign lane_result_flags = ge_reg;
	assign unaligned_fault   = fault_reg;
	assign pipe_busy         = state_reg == lspt_pkg::ST_BUSY;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset || !clk_en);

	sequence s_quiet2;
		(!mem_stall && !irq_req) [*2];
	endsequence
	sequence s_quiet4;
		(!mem_stall && !irq_req) [*4];
	endsequence

	chk_dsp_one_cycle: assert property (
		dsp_fire |=> dsp_res_reg == $past(dres))
		else $error("dsp result not ready after one cycle");
	chk_sat_sticky: assert property (
		dsp_fire && dsat |=> sat_reg)
		else $error("saturation did not set sticky flag");
	chk_store_one: assert property (
		fire && issue.op == lspt_pkg::OP_STORE && !issue.reg_off && !issue.excl
		&& !dep_dp && unal_pen == 8'h00 |=> state_reg == lspt_pkg::ST_IDLE)
		else $error("immediate store took more than one cycle");
	chk_hold_disabled: assert property (
		slot_hard_reg |-> !issue_ready)
		else $error("issue open behind disabled buffer store");
	chk_pc_load_block: assert property (
		fire && issue.op == lspt_pkg::OP_LOAD_PC |=> !issue_ready [*4])
		else $error("program counter load did not block five cycles");
	chk_tbranch_block: assert property (
		fire && issue.op == lspt_pkg::OP_TBRANCH |=> !issue_ready [*5])
		else $error("table branch did not block six cycles");
	chk_dep_stall: assert property (
		fire && is_single && dep_dp && !trap_hit
		|=> state_reg == lspt_pkg::ST_BUSY)
		else $error("dependent address took no extra cycle");
	chk_pipe_load: assert property (
		fire && issue.op == lspt_pkg::OP_LOAD && pipe_ok && unal_pen == 8'h00
		&& !issue.pc_rel |=> state_reg == lspt_pkg::ST_IDLE)
		else $error("pipelined load not reduced to one cycle");
	chk_pair_cost: assert property (
		fire && (issue.op == lspt_pkg::OP_LOAD_PAIR || issue.op == lspt_pkg::OP_STORE_PAIR)
		&& !dep_dp ##1 s_quiet2 |=> state_reg == lspt_pkg::ST_IDLE)
		else $error("pair transfer not three cycles");
	chk_multi_cost: assert property (
		fire && is_multi && !resume_reg && !dep_dp && issue.count == 5'h03
		##1 s_quiet4 |=> state_reg == lspt_pkg::ST_IDLE)
		else $error("three element multiple not five cycles");
	chk_slot_full: assert property (
		issue_valid && is_mem && slot_full_reg && !st_ready |-> !issue_ready)
		else $error("access issued while store slot full");

endmodule

/* verilog/lspt_dsp_sub.sv */
// Purpose: parallel subtract on 16-bit or 8-bit lanes, exchange add-subtract on 16-bit lanes only
// Assumes: purely combinational, result is registered by the caller
// Notes: sat reports only signed saturation, unsigned forms leave the sticky flag alone
`timescale 1ns/1ns
module lspt_dsp_sub (
	input  wire lspt_pkg::lspt_dctl_s ctl,
	input  wire logic [31:0]          opa,
	input  wire logic [31:0]          opb,
	output logic [31:0]               res,
	output logic [3:0]                ge,
	output logic                      sat
);
	logic [31:0] h_res;
	logic [31:0] b_res;
	logic [3:0]  h_ge;
	logic [3:0]  b_ge;
	logic [1:0]  h_sat;
	logic [3:0]  b_sat;

	// ----------------------------------------
	// halfword lanes
	// ----------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_half
		logic [15:0] x;
		logic [15:0] y;
		logic        add;
		logic [17:0] r;
		logic        ovh;
		logic        ovl;
		assign x = opa[16*i +: 16];
		// exchange forms pair each lane with the opposite half of b
		assign y = (ctl.kind == lspt_pkg::DK_SUB) ? opb[16*i +: 16] : opb[16*(1-i) +: 16];
		assign add = (ctl.kind == lspt_pkg::DK_ASX && i == 1) ||
			(ctl.kind == lspt_pkg::DK_SAX && i == 0);
		assign r = add ? {{2{ctl.sgn & x[15]}}, x} + {{2{ctl.sgn & y[15]}}, y}
			: {{2{ctl.sgn & x[15]}}, x} - {{2{ctl.sgn & y[15]}}, y};
		assign ovh = ctl.sgn ? (!r[17] && (r[16] || r[15])) : (!r[17] && r[16]);
		assign ovl = ctl.sgn ? (r[17] && !(r[16] && r[15])) : r[17];
		assign h_ge[2*i +: 2] = {2{(add && !ctl.sgn) ? r[16] : !r[17]}};
		assign h_sat[i] = ctl.sgn && (ctl.mode == lspt_pkg::DM_SAT) && (ovh || ovl);
		assign h_res[16*i +: 16] = (ctl.mode == lspt_pkg::DM_HALF) ? r[16:1] :
			(ctl.mode != lspt_pkg::DM_SAT) ? r[15:0] :
			ovh ? (ctl.sgn ? 16'h7fff : 16'hffff) :
			ovl ? (ctl.sgn ? 16'h8000 : 16'h0000) : r[15:0];
	end

	// ----------------------------------------
	// byte lanes, subtract only
	// ----------------------------------------
	for (genvar j = 0; j < 4; j++) begin : g_byte
		logic [7:0] x;
		logic [7:0] y;
		logic [9:0] r;
		logic       ovh;
		logic       ovl;
		assign x = opa[8*j +: 8];
		assign y = opb[8*j +: 8];
		assign r = {{2{ctl.sgn & x[7]}}, x} - {{2{ctl.sgn & y[7]}}, y};
		assign ovh = ctl.sgn && !r[9] && r[7];
		assign ovl = ctl.sgn ? (r[9] && !(r[8] && r[7])) : r[9];
		assign b_ge[j] = !r[9];
		assign b_sat[j] = ctl.sgn && (ctl.mode == lspt_pkg::DM_SAT) && (ovh || ovl);
		assign b_res[8*j +: 8] = (ctl.mode == lspt_pkg::DM_HALF) ? r[8:1] :
			(ctl.mode != lspt_pkg::DM_SAT) ? r[7:0] :
			ovh ? 8'h7f : ovl ? (ctl.sgn ? 8'h80 : 8'h00) : r[7:0];
	end

	assign res = ctl.lanes8 ? b_res : h_res;
	assign ge  = ctl.lanes8 ? b_ge : h_ge;
	assign sat = ctl.lanes8 ? (|b_sat) : (|h_sat);

endmodule

/* verilog/lspt_map.svh */
// Purpose: offsets, fields, reset values and cycle counts of the lsu timing block
// Assumes: included by the timing core
// Notes: offsets are byte addresses of 32-bit apb words
`ifndef LSPT_MAP_SVH
`define LSPT_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LSPT_OFF_CTRL      12'h000
`define LSPT_OFF_CFG       12'h004
`define LSPT_OFF_STATUS    12'h008
`define LSPT_OFF_FLAGS     12'h00c
`define LSPT_OFF_COST      12'h010

// ----------------------------------------
// field positions
// ----------------------------------------
`define LSPT_CTRL_WB_EN    0
`define LSPT_CFG_TRAP      0
`define LSPT_CFG_ALIGN     1
`define LSPT_STAT_BUSY     0
`define LSPT_STAT_SLOT     1
`define LSPT_STAT_HARD     2
`define LSPT_STAT_RESUME   3
`define LSPT_STAT_ELEMS    8
`define LSPT_FLAGS_SAT     4

// ----------------------------------------
// reset values
// ----------------------------------------
`define LSPT_RST_WB_EN     1'b1
`define LSPT_RST_TRAP      1'b0
`define LSPT_RST_ALIGN     1'b0

// ----------------------------------------
// cycle counts
// ----------------------------------------
`define LSPT_CYC_ONE       8'h01
`define LSPT_CYC_LOAD      8'h02
`define LSPT_CYC_ADD       8'h01
`define LSPT_CYC_REFILL    8'h03
`define LSPT_CYC_PAIR      8'h03
`define LSPT_CYC_FIRST     8'h02
`define LSPT_CYC_FINAL     8'h01
`define LSPT_CYC_RES_LD    8'h01
`define LSPT_CYC_RES_ST    8'h02

`endif

/* verilog/lspt_pkg.sv */
// Purpose: types of the lsu timing block
// Assumes: constants live in lspt_map.svh
// Notes: nothing is imported, names are scoped
package lspt_pkg;

	typedef enum logic [3:0] {
		OP_DP          = 4'h0,
		OP_DSP         = 4'h1,
		OP_LOAD        = 4'h2,
		OP_STORE       = 4'h3,
		OP_LOAD_PC     = 4'h4,
		OP_TBRANCH     = 4'h5,
		OP_LOAD_PAIR   = 4'h6,
		OP_STORE_PAIR  = 4'h7,
		OP_LOAD_MULTI  = 4'h8,
		OP_STORE_MULTI = 4'h9
	} lspt_op_e;

	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} lspt_size_e;
	typedef enum logic [1:0] {DK_SUB = 2'h0, DK_ASX = 2'h1, DK_SAX = 2'h2} lspt_dkind_e;
	typedef enum logic [1:0] {DM_FLAG = 2'h0, DM_SAT = 2'h1, DM_HALF = 2'h2} lspt_dmode_e;
	typedef enum logic {ST_IDLE = 1'b0, ST_BUSY = 1'b1} lspt_state_e;

	typedef struct packed {
		lspt_dkind_e kind;
		lspt_dmode_e mode;
		logic        lanes8;
		logic        sgn;
	} lspt_dctl_s;

	typedef struct packed {
		lspt_op_e    op;
		logic        excl;
		logic        reg_off;
		logic        pc_rel;
		logic        buffered;
		lspt_size_e  size;
		logic [4:0]  count;
		logic [3:0]  dest;
		logic [3:0]  base;
		logic [3:0]  index;
		logic [31:0] addr;
		logic [31:0] data;
		logic [31:0] opb;
		lspt_dctl_s  dctl;
	} lspt_issue_s;

	typedef struct packed {
		logic [31:0] addr;
		logic [31:0] data;
		lspt_size_e  size;
	} lspt_store_s;

endpackage
